// [design/uesb_map.vh]
// register indexes, field positions, reset values and limits for the uart status and baud block
`ifndef UESB_MAP_VH
`define UESB_MAP_VH

// word indexes on the avalon bus (byte address is four times the index)
`define UESB_IDX_STAT0 32'hfffff302
`define UESB_IDX_STAT1 32'hfffff312
`define UESB_IDX_DIV0 32'hfffff340
`define UESB_IDX_DIV1 32'hfffff341
`define UESB_IDX_CTRL0 32'hfffff342
`define UESB_IDX_CTRL1 32'hfffff343
`define UESB_IDX_IRQ_STAT 32'hfffff344
`define UESB_IDX_IRQ_EN 32'hfffff345
`define UESB_IDX_IRQ_CLR 32'hfffff346

// error status byte fields
`define UESB_STAT_OVE 0
`define UESB_STAT_FE 1
`define UESB_STAT_PE 2

// control byte fields (one per channel)
`define UESB_CTRL_ISRM 1
`define UESB_CTRL_UCL 3
`define UESB_CTRL_PS_LO 4
`define UESB_CTRL_PS_HI 5

// parity modes
`define UESB_PAR_NONE 2'h0
`define UESB_PAR_ZERO 2'h1
`define UESB_PAR_ODD 2'h2
`define UESB_PAR_EVEN 2'h3

// interrupt status layout: errors in bits 1:0, completions in bits 3:2
`define UESB_IRQ_ERR_LO 0
`define UESB_IRQ_DONE_LO 2
`define UESB_IRQ_W 4

// reset values
`define UESB_RST_STAT 8'h00
`define UESB_RST_DIV 8'h00
`define UESB_RST_CTRL 8'h00
`define UESB_RST_IRQ 4'h0

// smallest legal divisor
`define UESB_DIV_MIN 8'h08

`endif

// [design/uesb_top.v]
// receive error status, baud divisors and avalon register slave for a two channel uart
`timescale 1ns/1ps
`include "uesb_map.vh"

// How it works
// - errors set parity, framing, overrun bits; rest zero
// - error status byte is read only
// - reset clears both error status bytes
// - serial clock is source clock over divisor
// - divider counts only on selected source clock
// - divisor written only as whole byte
// - reset clears both divisors to zero
// - each character is checked, status updated
// - error control bit gates the RX_INT receive interrupt; the IRQ completion bits still set
module uesb_top (
    // clock and reset
    input wire MCLK,
    input wire SYS_RST,
    // avalon-mm slave, word addressed
    input wire [31:0] ADDRESS,
    input wire READ,
    input wire WRITE,
    input wire [3:0] BYTEENABLE,
    input wire [31:0] WRITEDATA,
    output reg [31:0] READDATA,
    output reg WAITREQUEST,
    // selected source clock, one enable pulse per source edge
    input wire [1:0] SRC_TICK,
    // receive controller, one bit per channel, RX_DATA one byte per channel
    input wire [1:0] RX_DONE,
    input wire [15:0] RX_DATA,
    input wire [1:0] RX_PAR_BIT,
    input wire [1:0] RX_STOP1,
    input wire [1:0] RX_BUF_RD,
    // serial clock and interrupts
    output reg [1:0] BAUD_TICK,
    output reg [1:0] RX_INT,
    output reg IRQ
);

    // things a user of this block should know:
    // - the error status byte is not sticky; every finished character
    //   overwrites all three flags, so read it before the next character
    // - divisor values 0 to 7 park the divider and give no serial clock,
    //   and reset leaves the divisor there, so program it before use
    // - a divisor write restarts the count; the first serial clock after
    //   it comes a full k source ticks later
    // - the source clock arrives as tick pulses; its selection is outside
    // - only the first stop bit is looked at, whatever stop length is set
    // - overrun needs a buffer read pulse between characters
    // - every access costs one wait cycle, reads and writes alike

    // bus handshake: waitrequest is high while idle and
    // drops for one cycle after a request is seen
    wire req = READ | WRITE;
    // a write lands at the edge where waitrequest is low
    wire wr_go = WRITE & ~WAITREQUEST;
    // whole byte lane zero must be enabled
    wire wr_byte = wr_go & BYTEENABLE[0];
    // read data is captured one cycle into the request
    wire rd_cap = READ & WAITREQUEST;

    // per channel results gathered for the bus and the interrupt logic
    wire [15:0] stat_all;
    wire [15:0] div_all;
    wire [15:0] ctrl_all;
    wire [1:0] err_ev;
    wire [1:0] done_ev;
    // per channel serial clock and receive interrupt, before the output flops;
    // assigned inside the channel loop, registered below
    wire [1:0] baud_all;
    wire [1:0] rxint_all;

    // interrupt registers shared by both channels
    reg [`UESB_IRQ_W-1:0] irq_stat_q;
    reg [`UESB_IRQ_W-1:0] irq_en_q;
    // a write to the clear register, low nibble used
    wire [`UESB_IRQ_W-1:0] irq_clr;
    // events of this cycle in interrupt layout
    wire [`UESB_IRQ_W-1:0] irq_set;

    assign irq_clr = (wr_byte && ADDRESS == `UESB_IDX_IRQ_CLR) ? WRITEDATA[`UESB_IRQ_W-1:0] : `UESB_RST_IRQ;
    assign irq_set = {done_ev, err_ev};

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : ch
            // this channel's register indexes
            wire [31:0] idx_div = i ? `UESB_IDX_DIV1 : `UESB_IDX_DIV0;
            wire [31:0] idx_ctrl = i ? `UESB_IDX_CTRL1 : `UESB_IDX_CTRL0;

            // software state
            reg [7:0] div_q; // divisor_value
            reg [7:0] ctrl_q; // mode bits kept locally
            // hardware state
            reg [7:0] stat_q; // error_status_byte
            reg unread_q; // receive_buffer holds unread data
            reg [7:0] cnt_q; // 8-bit divider counter

            // received character as seen by the checker
            wire [7:0] data = RX_DATA[8*i+7:8*i];
            // seven bit characters leave bit 7 out of parity
            wire [7:0] data_m = ctrl_q[`UESB_CTRL_UCL] ? data : {1'b0, data[6:0]};
            wire [1:0] pmode = ctrl_q[`UESB_CTRL_PS_HI:`UESB_CTRL_PS_LO];
            wire ones = ^data_m;
            reg par_err;

            // parity check per mode
            always @* begin
                case (pmode)
                    `UESB_PAR_ODD: par_err = ~(ones ^ RX_PAR_BIT[i]);
                    `UESB_PAR_EVEN: par_err = ones ^ RX_PAR_BIT[i];
                    // zero parity and no parity never flag an error
                    default: par_err = 1'b0;
                endcase
            end

            // only the first stop bit is sampled, two stop bits or not
            wire frm_err = ~RX_STOP1[i];
            // a character finishing while the buffer is still unread
            wire ove_err = unread_q & ~RX_BUF_RD[i];
            wire any_err = par_err | frm_err | ove_err;

            assign err_ev[i] = RX_DONE[i] & any_err;
            assign done_ev[i] = RX_DONE[i];
            assign stat_all[8*i+7:8*i] = stat_q;
            assign div_all[8*i+7:8*i] = div_q;
            assign ctrl_all[8*i+7:8*i] = ctrl_q;

            // whole byte writes aimed at this channel
            wire div_wr = wr_byte && ADDRESS == idx_div;
            wire ctrl_wr = wr_byte && ADDRESS == idx_ctrl;
            reg [7:0] div_d;
            reg [7:0] ctrl_d;

            // next divisor and control; partial writes that skip lane zero are dropped
            always @* begin
                div_d = div_q;
                ctrl_d = ctrl_q;
                if (div_wr) begin
                    div_d = WRITEDATA[7:0];
                end
                if (ctrl_wr) begin
                    ctrl_d = WRITEDATA[7:0];
                end
            end

            // divisor and control, software written
            always @(posedge MCLK) begin
                if (SYS_RST) begin
                    div_q <= `UESB_RST_DIV;
                    ctrl_q <= `UESB_RST_CTRL;
                end else begin
                    div_q <= div_d;
                    ctrl_q <= ctrl_d;
                end
            end

            // next error status byte, rewritten by every finished character
            reg [7:0] stat_d;
            always @* begin
                // no character, no change
                stat_d = stat_q;
                if (RX_DONE[i]) begin
                    // bits 7 to 3 always read zero
                    stat_d = 8'h00;
                    stat_d[`UESB_STAT_PE] = par_err;
                    stat_d[`UESB_STAT_FE] = frm_err;
                    stat_d[`UESB_STAT_OVE] = ove_err;
                end
            end

            // error status byte: no bus write path exists at all
            always @(posedge MCLK) begin
                if (SYS_RST) begin
                    stat_q <= `UESB_RST_STAT;
                end else begin
                    stat_q <= stat_d;
                end
            end

            // next unread state; a new character wins over a read in the same cycle
            reg unread_d;
            always @* begin
                unread_d = unread_q;
                if (RX_DONE[i]) begin
                    unread_d = 1'b1;
                end else if (RX_BUF_RD[i]) begin
                    unread_d = 1'b0;
                end
            end

            // unread tracking for the overrun check
            always @(posedge MCLK) begin
                if (SYS_RST) begin
                    unread_q <= 1'b0;
                end else begin
                    unread_q <= unread_d;
                end
            end

            // prohibited settings 0 to 7 stop the divider
            wire div_bad = div_q < `UESB_DIV_MIN;
            // last source tick of one serial clock period
            wire cnt_end = cnt_q == div_q - 8'h01;
            reg [7:0] cnt_d;
            reg baud_d;

            // next divider count and serial clock pulse
            always @* begin
                cnt_d = cnt_q;
                baud_d = 1'b0;
                // a write and a tick in one cycle: the write wins
                if (div_wr) begin
                    // restart so the new ratio starts from a clean phase
                    cnt_d = 8'h00;
                end else if (SRC_TICK[i]) begin
                    if (div_bad) begin
                        // prohibited setting: divider held, no serial clock
                        cnt_d = 8'h00;
                    end else if (cnt_end) begin
                        // one serial clock per k source clocks
                        cnt_d = 8'h00;
                        baud_d = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 8'h01;
                    end
                end
            end

            // divider counter; it moves only on the selected source clock or a divisor write
            always @(posedge MCLK) begin
                if (SYS_RST) begin
                    cnt_q <= 8'h00;
                end else begin
                    cnt_q <= cnt_d;
                end
            end

            // pulses handed to the shared output flops
            assign baud_all[i] = baud_d;
            // with the control bit set an erroneous character stays silent
            assign rxint_all[i] = RX_DONE[i] & ~(any_err & ctrl_q[`UESB_CTRL_ISRM]);
        end
    endgenerate

    // serial clock and receive interrupt pulses of both channels;
    // one process so each output has a single driver, straight from a flop
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            BAUD_TICK <= 2'h0;
            RX_INT <= 2'h0;
        end else begin
            BAUD_TICK <= baud_all;
            RX_INT <= rxint_all;
        end
    end

    // next sticky status: a new event beats a clear in the same cycle
    reg [`UESB_IRQ_W-1:0] irq_stat_d;
    always @* begin
        irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
    end

    // sticky interrupt status, cleared only by software
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            irq_stat_q <= `UESB_RST_IRQ;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // next enable mask, same layout as the status bits
    reg [`UESB_IRQ_W-1:0] irq_en_d;
    always @* begin
        irq_en_d = irq_en_q;
        // writes without lane zero leave the mask alone
        if (wr_byte && ADDRESS == `UESB_IDX_IRQ_EN) begin
            irq_en_d = WRITEDATA[`UESB_IRQ_W-1:0];
        end
    end

    // interrupt enable register
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            irq_en_q <= `UESB_RST_IRQ;
        end else begin
            irq_en_q <= irq_en_d;
        end
    end

    // level interrupt, one cycle behind the status bits
    wire irq_d = |(irq_stat_q & irq_en_q);
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
        end else begin
            // high while any enabled status bit is set
            IRQ <= irq_d;
        end
    end

    // read mux; unmapped indexes and the clear register read zero
    reg [7:0] rd_mux;
    always @* begin
        case (ADDRESS)
            `UESB_IDX_STAT0: rd_mux = stat_all[7:0];
            `UESB_IDX_STAT1: rd_mux = stat_all[15:8];
            `UESB_IDX_DIV0: rd_mux = div_all[7:0];
            `UESB_IDX_DIV1: rd_mux = div_all[15:8];
            `UESB_IDX_CTRL0: rd_mux = ctrl_all[7:0];
            `UESB_IDX_CTRL1: rd_mux = ctrl_all[15:8];
            `UESB_IDX_IRQ_STAT: rd_mux = {4'h0, irq_stat_q};
            `UESB_IDX_IRQ_EN: rd_mux = {4'h0, irq_en_q};
            default: rd_mux = 8'h00;
        endcase
    end

    // next handshake and read data; a read captures one cycle into the request
    reg wait_d;
    reg [31:0] rdata_d;
    always @* begin
        // low for exactly one cycle after a request, then high again
        wait_d = ~(req & WAITREQUEST);
        // read data stands until the next read
        rdata_d = READDATA;
        if (rd_cap) begin
            // narrow data sits in the low byte, upper bits zero
            rdata_d = {24'h000000, rd_mux};
        end
    end

    // waitrequest and read data: fixed one wait cycle per access
    always @(posedge MCLK) begin
        if (SYS_RST) begin
            WAITREQUEST <= 1'b1;
            READDATA <= 32'h00000000;
        end else begin
            WAITREQUEST <= wait_d;
            READDATA <= rdata_d;
        end
    end

endmodule

// [tb/uesb_chk.sv]
// port checker for the uart status and baud block
`timescale 1ns/1ps
`include "uesb_map.vh"
module uesb_chk (
    // clock, reset and bus
    input wire logic MCLK, SYS_RST, READ, WRITE, WAITREQUEST,
    input wire logic [31:0] ADDRESS, WRITEDATA, READDATA,
    input wire logic [3:0] BYTEENABLE,
    // events, ticks and interrupts
    input wire logic [1:0] SRC_TICK, RX_DONE, BAUD_TICK, RX_INT,
    input wire logic IRQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // clear-all write landing with no event in the same cycle
    sequence s_clr;
        WRITE && !WAITREQUEST && BYTEENABLE[0] && ADDRESS == `UESB_IDX_IRQ_CLR && WRITEDATA[3:0] == 4'hf
            && RX_DONE == 2'h0;
    endsequence
    // enable register written to all zero
    sequence s_mask;
        WRITE && !WAITREQUEST && BYTEENABLE[0] && ADDRESS == `UESB_IDX_IRQ_EN && WRITEDATA[3:0] == 4'h0;
    endsequence
    a_wait_one_cycle: assert property (!WAITREQUEST |=> WAITREQUEST)
        else $error("waitrequest low too long");
    a_req_answered: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
        else $error("request not answered next cycle");
    a_stat_high_zero: assert property (READ && !WAITREQUEST && (ADDRESS == `UESB_IDX_STAT0
        || ADDRESS == `UESB_IDX_STAT1) |-> READDATA[31:3] == 29'h0) else $error("status upper bits set");
    a_baud_from_src: assert property ((BAUD_TICK & ~$past(SRC_TICK)) == 2'h0)
        else $error("baud tick without source tick");
    a_baud_min_gap: assert property (BAUD_TICK[0] |=> !BAUD_TICK[0] [*7])
        else $error("baud ticks closer than eight");
    a_int_from_done: assert property ((RX_INT & ~$past(RX_DONE)) == 2'h0)
        else $error("receive interrupt without character");
    a_irq_clear_drop: assert property (s_clr |-> ##2 !IRQ)
        else $error("irq still high after clear");
    a_irq_mask_drop: assert property (s_mask |-> ##2 !IRQ)
        else $error("irq still high after mask");
    a_reset_quiet: assert property ($fell(SYS_RST) |-> WAITREQUEST && !IRQ && RX_INT == 2'h0
        && BAUD_TICK == 2'h0) else $error("outputs busy after reset");
endmodule
bind uesb_top uesb_chk chk (.MCLK(MCLK), .SYS_RST(SYS_RST), .READ(READ), .WRITE(WRITE), .WAITREQUEST(WAITREQUEST),
    .ADDRESS(ADDRESS), .WRITEDATA(WRITEDATA), .READDATA(READDATA), .BYTEENABLE(BYTEENABLE),
    .SRC_TICK(SRC_TICK), .RX_DONE(RX_DONE), .BAUD_TICK(BAUD_TICK), .RX_INT(RX_INT), .IRQ(IRQ));

// [tb/uesb_rx_model.sv]
// receive side model: characters, buffer reads and source ticks
`timescale 1ns/1ps
module uesb_rx_model (
    // clock and interrupt back
    input wire logic MCLK,
    input wire logic [1:0] RX_INT,
    // events and ticks
    output logic [1:0] SRC_TICK, RX_DONE, RX_PAR_BIT, RX_STOP1, RX_BUF_RD,
    output logic [15:0] RX_DATA
);
    // everything quiet at time zero
    initial begin
        SRC_TICK = 2'h0;
        RX_DONE = 2'h0;
        RX_PAR_BIT = 2'h0;
        RX_STOP1 = 2'h3;
        RX_BUF_RD = 2'h0;
        RX_DATA = 16'h0;
    end
    // one character; flags only hold with done, then invert so stale data never matches
    task send(input int ch, input logic [7:0] d, input logic pb, st, output logic seen);
        @(posedge MCLK);
        RX_DONE[ch] <= 1'b1;
        RX_DATA[ch*8+:8] <= d;
        RX_PAR_BIT[ch] <= pb;
        RX_STOP1[ch] <= st; // only the first stop is reported
        @(posedge MCLK);
        RX_DONE[ch] <= 1'b0;
        RX_DATA[ch*8+:8] <= ~d;
        RX_PAR_BIT[ch] <= ~pb;
        RX_STOP1[ch] <= ~st;
        // the pulse launched at the done edge is read at the following edge
        @(posedge MCLK);
        seen = RX_INT[ch];
    endtask
    // buffer read pulse
    task rdbuf(input int ch);
        @(posedge MCLK);
        RX_BUF_RD[ch] <= 1'b1;
        @(posedge MCLK);
        RX_BUF_RD[ch] <= 1'b0;
    endtask
    // n back to back source ticks
    task ticks(input int ch, input int n);
        repeat (n) begin
            @(posedge MCLK);
            SRC_TICK[ch] <= 1'b1;
        end
        @(posedge MCLK);
        SRC_TICK[ch] <= 1'b0;
    endtask
endmodule

// [tb/tb_uesb_top.sv]
// self-checking bench for the uart status and baud block
`timescale 1ns/1ps
`include "uesb_map.vh"
module tb_uesb_top;
    logic MCLK = 1'b0, SYS_RST = 1'b1, READ = 1'b0, WRITE = 1'b0, WAITREQUEST, IRQ, seen, b_rd, pb, st;
    logic [31:0] ADDRESS = 32'h0, WRITEDATA = 32'h0, READDATA, rv;
    logic [3:0] BYTEENABLE = 4'h0;
    logic [1:0] SRC_TICK, RX_DONE, RX_PAR_BIT, RX_STOP1, RX_BUF_RD, BAUD_TICK, RX_INT;
    logic [15:0] RX_DATA;
    logic [7:0] d, e;
    logic [18:0] tbl [4] = '{{1'b0, 8'h01, 2'b01, 8'h04}, {1'b1, 8'h03, 2'b00, 8'h02},
        {1'b0, 8'h03, 2'b01, 8'h01}, {1'b1, 8'h03, 2'b01, 8'h00}}; // read first, data, parity, stop, status
    int n_errors = 0, checks = 0, nb = 0, n0;
    uesb_top dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
        .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
        .SRC_TICK(SRC_TICK), .RX_DONE(RX_DONE), .RX_DATA(RX_DATA), .RX_PAR_BIT(RX_PAR_BIT), .RX_STOP1(RX_STOP1),
        .RX_BUF_RD(RX_BUF_RD), .BAUD_TICK(BAUD_TICK), .RX_INT(RX_INT), .IRQ(IRQ));
    uesb_rx_model far (.MCLK(MCLK), .RX_INT(RX_INT), .SRC_TICK(SRC_TICK), .RX_DONE(RX_DONE),
        .RX_PAR_BIT(RX_PAR_BIT), .RX_STOP1(RX_STOP1), .RX_BUF_RD(RX_BUF_RD), .RX_DATA(RX_DATA));
    // 125 mhz clock
    initial forever #4 MCLK = ~MCLK;
    // count channel 0 baud ticks
    always @(posedge MCLK) if (BAUD_TICK[0] === 1'b1) nb <= nb + 1;
    task end_sim;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, x, input string nm);
        checks++;
        if (s !== x) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask
    // one avalon access held until waitrequest low, then an idle cycle
    task acc(input logic w, input logic [31:0] a, dt, input logic [3:0] be);
        int i;
        READ <= !w;
        WRITE <= w;
        ADDRESS <= a;
        WRITEDATA <= dt;
        BYTEENABLE <= be;
        i = 0;
        do begin
            @(posedge MCLK);
            i++;
        end while (WAITREQUEST !== 1'b0 && i < 50);
        rv = READDATA;
        READ <= 1'b0;
        WRITE <= 1'b0;
        @(posedge MCLK);
        if (i >= 50) begin
            n_errors++;
            end_sim;
        end
    endtask
    task wr(input logic [31:0] a, dt);
        acc(1'b1, a, dt, 4'h1);
    endtask
    task rd(input logic [31:0] a, x, input string nm);
        acc(1'b0, a, 32'h0, 4'h1);
        chk(rv, x, nm);
    endtask
    initial begin
        repeat (6) @(posedge MCLK);
        SYS_RST <= 1'b0;
        @(posedge MCLK);
        rd(`UESB_IDX_STAT0, 32'h0, "stat0");
        rd(`UESB_IDX_STAT1, 32'h0, "stat1");
        rd(`UESB_IDX_DIV0, 32'h0, "div0");
        rd(`UESB_IDX_DIV1, 32'h0, "div1");
        rd(32'hfffff3f0, 32'h0, "unmapped");
        wr(`UESB_IDX_DIV0, 32'h08);
        acc(1'b1, `UESB_IDX_DIV0, 32'h55, 4'h2); // partial write must not land
        rd(`UESB_IDX_DIV0, 32'h08, "div0");
        wr(`UESB_IDX_DIV1, 32'hff);
        rd(`UESB_IDX_DIV1, 32'hff, "div1");
        wr(`UESB_IDX_STAT0, 32'h07);
        rd(`UESB_IDX_STAT0, 32'h0, "stat0 ro");
        n0 = nb;
        // 56 ticks tell a ratio of 8 apart from 7 and from 9
        far.ticks(0, 56);
        repeat (2) @(posedge MCLK);
        chk(nb - n0, 7, "baud div8");
        wr(`UESB_IDX_DIV0, 32'h07);
        n0 = nb;
        far.ticks(0, 24);
        repeat (2) @(posedge MCLK);
        chk(nb - n0, 0, "baud div7");
        wr(`UESB_IDX_CTRL0, 32'h38);
        wr(`UESB_IDX_IRQ_EN, 32'h1);
        for (int k = 0; k < 4; k++) begin
            {b_rd, d, pb, st, e} = tbl[k];
            if (b_rd) far.rdbuf(0);
            far.send(0, d, pb, st, seen);
            chk(32'(seen), 32'h1, "rx int");
            rd(`UESB_IDX_STAT0, 32'(e), "stat0 err");
        end
        chk(32'(IRQ), 32'h1, "irq on");
        wr(`UESB_IDX_IRQ_EN, 32'h0);
        rd(`UESB_IDX_IRQ_STAT, 32'h5, "irq stat");
        chk(32'(IRQ), 32'h0, "irq masked");
        wr(`UESB_IDX_IRQ_EN, 32'hf);
        wr(`UESB_IDX_IRQ_CLR, 32'hf);
        rd(`UESB_IDX_IRQ_STAT, 32'h0, "irq cleared");
        chk(32'(IRQ), 32'h0, "irq off");
        wr(`UESB_IDX_CTRL0, 32'h3a);
        far.rdbuf(0);
        far.send(0, 8'h01, 1'b0, 1'b1, seen);
        chk(32'(seen), 32'h0, "rx int suppressed");
        far.rdbuf(0);
        far.send(0, 8'h03, 1'b0, 1'b1, seen);
        chk(32'(seen), 32'h1, "rx int clean");
        wr(`UESB_IDX_CTRL1, 32'h28);
        far.send(1, 8'h01, 1'b1, 1'b1, seen);
        rd(`UESB_IDX_STAT1, 32'h04, "stat1 odd");
        rd(`UESB_IDX_STAT0, 32'h0, "stat0 apart");
        // second reset in mid-run: status byte and divisor were nonzero before it
        SYS_RST <= 1'b1;
        repeat (2) @(posedge MCLK);
        SYS_RST <= 1'b0;
        @(posedge MCLK);
        rd(`UESB_IDX_STAT1, 32'h0, "stat1 reset");
        rd(`UESB_IDX_DIV1, 32'h0, "div1 reset");
        end_sim;
    end
endmodule
